// >>> verilog/swr_pkg.sv
package swr_pkg;
	// Fixed 7-bit slave address and the two direction values.
	localparam logic [6:0] SLAVE_ADDR = 7'h09;
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ = 1'b1;
	// Bit positions within a byte and the acknowledge slot.
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_FIRST = 4'h0;
	// Register addresses watched by the inactivity timer, then register reset value and depth.
	localparam logic [7:0] REG_CHARGE_CURRENT = 8'h14;
	localparam logic [7:0] REG_MAX_SYS_VOLTAGE = 8'h15;
	localparam logic [15:0] REG_RESET_VAL = 16'h0000;
	localparam int REG_DEPTH = 256;
	// Clock and timing.
	localparam longint CLK_HZ = 20000000;
	localparam longint TIMEOUT_S = 175;
	localparam longint TIMEOUT_CYCLES = TIMEOUT_S * CLK_HZ;
	localparam longint SCL_PERIOD_NS = 10000;
	localparam longint CLK_PERIOD_NS = 1000000000 / CLK_HZ;
	// One SCL period is four quarters; low and high each take two.
	localparam logic [7:0] QTR_CYCLES = 8'(SCL_PERIOD_NS / (4 * CLK_PERIOD_NS));
	typedef enum logic [1:0] {SWR_Q0, SWR_Q1, SWR_Q2, SWR_Q3} swr_qtr_t;
	// Host transaction steps.
	localparam logic [2:0] STEP_FIRST = 3'h0;
	localparam logic [2:0] STEP_WR_STOP = 3'h5;
	localparam logic [2:0] STEP_RD_STOP = 3'h7;
endpackage

// >>> verilog/swr_if.sv
`timescale 1ns/100ps
`default_nettype none
interface swr_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// Open-drain wired-AND with pull-ups; an enabled driver pulls to its level.
	assign scl = host_scl_oe ? host_scl_o : 1'b1;
	assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
	modport host (output host_scl_o, output host_scl_oe, output host_sda_o,
		output host_sda_oe, input scl, input sda);
	modport dev (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

// >>> verilog/swr_dev.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - SDA changes only while SCL low.
// - SDA fall with SCL high starts transaction.
// - SDA rise with SCL high ends transaction.
// - Nine SCL pulses per byte, ninth acknowledges.
// - Master sends address 0001001 plus direction.
// - Direction bit 0 writes, 1 reads.
// - Device pulls SDA low on address match.
// - Mismatch or not ready leaves SDA high.
// - Second byte is the register address.
// - Device acknowledges the register address byte.
// - Receiver acknowledges every matched address and data byte; the host refuses the high read byte.
// - Eight bits per byte, MSB first.
// - Word sent low byte then high byte.
// - Master transfers two data bytes per access.
// - Only Read-word and Write-word formats used.
// - Device never starts traffic nor drives SCL.
// - Commands accepted only after reset completes.
// - Read control 0x13, write control 0x12.
// - Slave address is a build-time parameter.
// - Timeout stops charging without setting writes.
module swr_dev #(
	parameter logic [6:0] SLAVE_ADDR = swr_pkg::SLAVE_ADDR,
	parameter logic [31:0] TIMEOUT_CYCLES = 32'(swr_pkg::TIMEOUT_CYCLES)
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	swr_if.dev bus,
	input wire logic link_ready_i,
	input wire logic timeout_en_i,
	output logic [15:0] charge_current_setting_o,
	output logic [15:0] max_system_voltage_setting_o,
	output logic charge_stop_o,
	output logic wr_strobe_o
);
	typedef enum logic [2:0] {
		SWR_IDLE, SWR_CTRL, SWR_REG, SWR_WDATA, SWR_RLOAD, SWR_RDATA, SWR_IGNORE
	} swr_state_t;

	swr_state_t state_q;
	logic scl_q;
	logic sda_q;
	logic [3:0] bit_q;
	logic [7:0] rx_q;
	logic [7:0] tx_q;
	logic [7:0] ptr_q;
	logic [7:0] lo_q;
	logic hi_q;
	logic mack_q;
	logic sda_oe_q;
	logic wr_en;
	logic [15:0] wr_word;
	logic [15:0] mem_q [swr_pkg::REG_DEPTH];
	logic [31:0] idle_cnt_q;
	logic start_det;
	logic stop_det;
	logic scl_rise;
	logic scl_fall;

	// The device never has an SCL driver at all, so it cannot stretch or start.
	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe = sda_oe_q;
	assign start_det = scl_q && bus.scl && sda_q && !bus.sda;
	assign stop_det = scl_q && bus.scl && !sda_q && bus.sda;
	assign scl_rise = !scl_q && bus.scl;
	assign scl_fall = scl_q && !bus.scl;
	assign wr_word = {rx_q, lo_q};
	assign wr_en = scl_fall && (bit_q == swr_pkg::BIT_LAST) && (state_q == SWR_WDATA) && hi_q;

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= bus.scl;
			sda_q <= bus.sda;
		end
	end

	// Bits are sampled on the rising SCL edge, MSB first.
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			rx_q <= 8'h00;
			mack_q <= 1'b1;
		end
		else if (scl_rise && bit_q != swr_pkg::BIT_ACK)
		begin
			rx_q <= {rx_q[6:0], bus.sda};
		end
		else if (scl_rise)
		begin
			mack_q <= bus.sda;
		end
	end

	// Protocol engine. SDA moves only on SCL falls; ignored frames still count them to free SDA.
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			state_q <= SWR_IDLE;
			bit_q <= swr_pkg::BIT_FIRST;
			sda_oe_q <= 1'b0;
			ptr_q <= 8'h00;
			lo_q <= 8'h00;
			hi_q <= 1'b0;
			tx_q <= 8'h00;
		end
		else if (start_det)
		begin
			// A repeated start restarts decoding but keeps the register pointer.
			state_q <= SWR_CTRL;
			// The fall after a start opens the first bit slot, as an acknowledge fall does.
			bit_q <= swr_pkg::BIT_ACK;
			sda_oe_q <= 1'b0;
		end
		else if (stop_det)
		begin
			state_q <= SWR_IDLE;
			sda_oe_q <= 1'b0;
		end
		else if (scl_fall && state_q != SWR_IDLE)
		begin
			if (bit_q == swr_pkg::BIT_LAST)
			begin
				bit_q <= swr_pkg::BIT_ACK;
				sda_oe_q <= 1'b1;
				case (state_q)
					SWR_CTRL:
					begin
						if (rx_q[7:1] == SLAVE_ADDR && link_ready_i)
						begin
							state_q <= (rx_q[0] == swr_pkg::DIR_READ) ? SWR_RLOAD : SWR_REG;
						end
						else
						begin
							state_q <= SWR_IGNORE;
							sda_oe_q <= 1'b0;
						end
					end
					SWR_REG:
					begin
						ptr_q <= rx_q;
						hi_q <= 1'b0;
						state_q <= SWR_WDATA;
					end
					SWR_WDATA:
					begin
						lo_q <= rx_q;
						hi_q <= 1'b1;
						// Bytes past the high byte are refused: only word writes exist.
						if (hi_q)
						begin
							state_q <= SWR_IGNORE;
						end
					end
					default:
					begin
						sda_oe_q <= 1'b0;
					end
				endcase
			end
			else if (bit_q == swr_pkg::BIT_ACK)
			begin
				bit_q <= swr_pkg::BIT_FIRST;
				sda_oe_q <= 1'b0;
				if (state_q == SWR_RLOAD)
				begin
					state_q <= SWR_RDATA;
					hi_q <= 1'b0;
					tx_q <= mem_q[ptr_q][7:0];
					sda_oe_q <= !mem_q[ptr_q][7];
				end
				else if (state_q == SWR_RDATA && !mack_q && !hi_q)
				begin
					hi_q <= 1'b1;
					tx_q <= mem_q[ptr_q][15:8];
					sda_oe_q <= !mem_q[ptr_q][15];
				end
				else if (state_q == SWR_RDATA)
				begin
					state_q <= SWR_IGNORE;
				end
			end
			else
			begin
				bit_q <= bit_q + 4'h1;
				if (state_q == SWR_RDATA)
				begin
					tx_q <= {tx_q[6:0], 1'b0};
					sda_oe_q <= !tx_q[6];
				end
			end
		end
	end

	// Register words; the high byte completes the write.
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			for (int i = 0; i < swr_pkg::REG_DEPTH; i++)
			begin
				mem_q[i] <= swr_pkg::REG_RESET_VAL;
			end
		end
		else if (wr_en)
		begin
			mem_q[ptr_q] <= wr_word;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			charge_current_setting_o <= swr_pkg::REG_RESET_VAL;
			max_system_voltage_setting_o <= swr_pkg::REG_RESET_VAL;
			wr_strobe_o <= 1'b0;
		end
		else
		begin
			wr_strobe_o <= wr_en;
			if (wr_en && ptr_q == swr_pkg::REG_CHARGE_CURRENT)
			begin
				charge_current_setting_o <= wr_word;
			end
			if (wr_en && ptr_q == swr_pkg::REG_MAX_SYS_VOLTAGE)
			begin
				max_system_voltage_setting_o <= wr_word;
			end
		end
	end

	// Only writes to the two setting registers keep charging alive.
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			idle_cnt_q <= 32'h0;
			charge_stop_o <= 1'b0;
		end
		else if (wr_en && (ptr_q == swr_pkg::REG_CHARGE_CURRENT
			|| ptr_q == swr_pkg::REG_MAX_SYS_VOLTAGE))
		begin
			idle_cnt_q <= 32'h0;
			charge_stop_o <= 1'b0;
		end
		else if (!timeout_en_i)
		begin
			idle_cnt_q <= 32'h0;
			charge_stop_o <= 1'b0;
		end
		else if (idle_cnt_q >= TIMEOUT_CYCLES - 32'h1)
		begin
			charge_stop_o <= 1'b1;
		end
		else
		begin
			idle_cnt_q <= idle_cnt_q + 32'h1;
		end
	end
endmodule
`default_nettype wire

// >>> verilog/swr_host.sv
`timescale 1ns/100ps
`default_nettype none
module swr_host #(
	parameter logic [6:0] SLAVE_ADDR = swr_pkg::SLAVE_ADDR
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	swr_if.host bus,
	input wire logic cmd_valid_i,
	input wire logic cmd_rd_i,
	input wire logic [7:0] cmd_reg_i,
	input wire logic [15:0] cmd_wdata_i,
	output logic cmd_ready_o,
	output logic rsp_valid_o,
	output logic rsp_nack_o,
	output logic [15:0] rsp_rdata_o
);
	typedef enum logic [1:0] {SWR_OP_START, SWR_OP_TX, SWR_OP_RX, SWR_OP_STOP} swr_op_t;

	logic busy_q;
	logic rd_q;
	logic [7:0] reg_q;
	logic [15:0] wd_q;
	logic [2:0] step_q;
	swr_pkg::swr_qtr_t qtr_q;
	logic [7:0] div_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic scl_oe_q;
	logic sda_oe_q;
	logic tick;
	swr_op_t op;
	logic [7:0] tx_byte;

	assign bus.host_scl_o = 1'b0;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_scl_oe = scl_oe_q;
	assign bus.host_sda_oe = sda_oe_q;
	assign tick = busy_q && div_q == swr_pkg::QTR_CYCLES - 8'h1;

	// Write-word: start, ctrl W, reg, lo, hi, stop.
	// Read-word: start, ctrl W, reg, start, ctrl R, lo, hi, stop.
	always_comb
	begin
		op = SWR_OP_TX;
		tx_byte = {SLAVE_ADDR, swr_pkg::DIR_WRITE};
		case (step_q)
			3'h0: op = SWR_OP_START;
			3'h2: tx_byte = reg_q;
			3'h3:
			begin
				op = rd_q ? SWR_OP_START : SWR_OP_TX;
				tx_byte = wd_q[7:0];
			end
			3'h4: tx_byte = rd_q ? {SLAVE_ADDR, swr_pkg::DIR_READ} : wd_q[15:8];
			3'h5: op = rd_q ? SWR_OP_RX : SWR_OP_STOP;
			3'h6: op = SWR_OP_RX;
			3'h7: op = SWR_OP_STOP;
			default: op = SWR_OP_TX;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i || !busy_q || tick)
		begin
			div_q <= 8'h00;
		end
		else
		begin
			div_q <= div_q + 8'h1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			busy_q <= 1'b0;
			cmd_ready_o <= 1'b1;
			rsp_valid_o <= 1'b0;
			rsp_nack_o <= 1'b0;
			rsp_rdata_o <= 16'h0000;
			rd_q <= 1'b0;
			reg_q <= 8'h00;
			wd_q <= 16'h0000;
			step_q <= swr_pkg::STEP_FIRST;
			qtr_q <= swr_pkg::SWR_Q0;
			bit_q <= swr_pkg::BIT_FIRST;
			sh_q <= 8'hff;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end
		else if (!busy_q)
		begin
			rsp_valid_o <= 1'b0;
			if (cmd_valid_i && cmd_ready_o)
			begin
				busy_q <= 1'b1;
				cmd_ready_o <= 1'b0;
				rsp_nack_o <= 1'b0;
				rd_q <= cmd_rd_i;
				reg_q <= cmd_reg_i;
				wd_q <= cmd_wdata_i;
				step_q <= swr_pkg::STEP_FIRST;
				qtr_q <= swr_pkg::SWR_Q0;
				bit_q <= swr_pkg::BIT_FIRST;
			end
		end
		else if (tick)
		begin
			qtr_q <= swr_pkg::swr_qtr_t'(qtr_q + 2'h1);
			case (qtr_q)
				swr_pkg::SWR_Q0:
				begin
					scl_oe_q <= 1'b1;
					if (bit_q == swr_pkg::BIT_FIRST)
					begin
						sh_q <= (op == SWR_OP_TX) ? tx_byte : 8'hff;
					end
				end
				swr_pkg::SWR_Q1:
				begin
					// Data and acknowledge SDA moves in the middle of the low phase; start and stop move it in the high phase.
					case (op)
						SWR_OP_START: sda_oe_q <= 1'b0;
						SWR_OP_STOP: sda_oe_q <= 1'b1;
						default:
						begin
							if (bit_q != swr_pkg::BIT_ACK)
							begin
								sda_oe_q <= !sh_q[7];
							end
							else
							begin
								// Acknowledge the low byte, refuse the high one.
								sda_oe_q <= (op == SWR_OP_RX) && step_q == 3'h5;
							end
						end
					endcase
				end
				swr_pkg::SWR_Q2:
				begin
					scl_oe_q <= 1'b0;
				end
				default:
				begin
					if (op == SWR_OP_START)
					begin
						sda_oe_q <= 1'b1;
						step_q <= step_q + 3'h1;
					end
					else if (op == SWR_OP_STOP)
					begin
						sda_oe_q <= 1'b0;
						busy_q <= 1'b0;
						cmd_ready_o <= 1'b1;
						rsp_valid_o <= 1'b1;
					end
					else if (bit_q != swr_pkg::BIT_ACK)
					begin
						sh_q <= {sh_q[6:0], bus.sda};
						bit_q <= bit_q + 4'h1;
					end
					else
					begin
						bit_q <= swr_pkg::BIT_FIRST;
						if (op == SWR_OP_RX && step_q == 3'h5)
						begin
							rsp_rdata_o[7:0] <= sh_q;
						end
						if (op == SWR_OP_RX && step_q == 3'h6)
						begin
							rsp_rdata_o[15:8] <= sh_q;
						end
						if (op == SWR_OP_TX && bus.sda)
						begin
							rsp_nack_o <= 1'b1;
							step_q <= rd_q ? swr_pkg::STEP_RD_STOP : swr_pkg::STEP_WR_STOP;
						end
						else
						begin
							step_q <= step_q + 3'h1;
						end
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> tb/swr_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module swr_monitor (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic link_ready_i,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic scl_q;
	logic sda_q;
	logic rd_q;
	logic nack_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic [2:0] bidx_q;
	logic start_w;
	logic stop_w;
	logic ack_w;
	assign start_w = scl && scl_q && sda_q && !sda;
	assign stop_w = scl && scl_q && !sda_q && sda;
	assign ack_w = scl && !scl_q && cnt_q == 4'h8;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	always_ff @(posedge clk_i)
	begin
		scl_q <= scl;
		sda_q <= sda;
	end
	// The closing start or stop brings its own SCL rise, so a clean frame ends on one.
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i || start_w || stop_w)
			cnt_q <= 4'h0;
		else if (scl && !scl_q)
			cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
	end
	always_ff @(posedge clk_i)
	begin
		if (scl && !scl_q)
			sh_q <= {sh_q[6:0], sda};
	end
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i || start_w)
		begin
			bidx_q <= 3'h0;
			nack_q <= 1'b0;
		end
		else if (ack_w)
		begin
			bidx_q <= bidx_q + 3'h1;
			if (bidx_q == 3'h0)
			begin
				rd_q <= sh_q[0];
				nack_q <= sda;
			end
		end
	end
	a_dev_sda_stable: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("device sda moved while scl high");
	a_start_by_host: assert property (start_w |-> host_sda_oe)
		else $error("start not made by host");
	a_nine_pulses: assert property (start_w || stop_w |-> cnt_q == 4'h1)
		else $error("frame not a whole number of nine-pulse bytes");
	a_addr_ack: assert property (ack_w && bidx_q == 3'h0 && link_ready_i
		&& sh_q[7:1] == swr_pkg::SLAVE_ADDR |-> !sda)
		else $error("own address not acknowledged");
	a_addr_nack: assert property (ack_w && bidx_q == 3'h0
		&& (!link_ready_i || sh_q[7:1] != swr_pkg::SLAVE_ADDR) |-> sda)
		else $error("address acknowledged while not ready");
	a_ignore_rest: assert property (nack_q |-> !dev_sda_oe)
		else $error("device drove sda after refusing address");
	a_data_ack: assert property (ack_w && !nack_q
		&& (bidx_q == 3'h1 || !rd_q && bidx_q < 3'h4) |-> !sda)
		else $error("byte not acknowledged");
	a_last_nack: assert property (ack_w && rd_q && bidx_q == 3'h2 |-> sda)
		else $error("last read byte not refused");
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam int TO_CYC = 2000;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic cmd_valid_i = 1'b0;
	logic cmd_rd_i = 1'b0;
	logic link_ready_i = 1'b1;
	logic timeout_en_i = 1'b0;
	logic [7:0] cmd_reg_i = 8'h00;
	logic [15:0] cmd_wdata_i = 16'h0000;
	logic cmd_ready_o;
	logic rsp_valid_o;
	logic rsp_nack_o;
	logic charge_stop_o;
	logic wr_strobe_o;
	logic [15:0] rsp_rdata_o;
	logic [15:0] cur_set;
	logic [15:0] volt_set;
	logic [7:0] r;
	logic [15:0] d;
	int err_total = 0;
	int samples_checked = 0;
	int n_wr = 0;
	int seen_wr = 0;
	int mdl[256];
	swr_if u_swr_if ();
	swr_dev #(.TIMEOUT_CYCLES(32'(TO_CYC))) u_swr_dev (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.bus(u_swr_if),
		.link_ready_i(link_ready_i),
		.timeout_en_i(timeout_en_i),
		.charge_current_setting_o(cur_set),
		.max_system_voltage_setting_o(volt_set),
		.charge_stop_o(charge_stop_o),
		.wr_strobe_o(wr_strobe_o)
	);
	swr_host u_swr_host (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.bus(u_swr_if),
		.cmd_valid_i(cmd_valid_i),
		.cmd_rd_i(cmd_rd_i),
		.cmd_reg_i(cmd_reg_i),
		.cmd_wdata_i(cmd_wdata_i),
		.cmd_ready_o(cmd_ready_o),
		.rsp_valid_o(rsp_valid_o),
		.rsp_nack_o(rsp_nack_o),
		.rsp_rdata_o(rsp_rdata_o)
	);
	swr_monitor u_swr_monitor (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.link_ready_i(link_ready_i),
		.host_sda_oe(u_swr_if.host_sda_oe),
		.dev_sda_oe(u_swr_if.dev_sda_oe),
		.scl(u_swr_if.scl),
		.sda(u_swr_if.sda)
	);
	always #25 clk_i = ~clk_i;
	always @(posedge clk_i)
		if (wr_strobe_o === 1'b1)
			seen_wr++;
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	// One bound covers accept and answer; a word read takes about 9600 cycles.
	task automatic xfer(input logic rd, input logic [7:0] ra, input logic [15:0] wd);
		int n;
		n = 0;
		cmd_valid_i <= 1'b1;
		cmd_rd_i <= rd;
		cmd_reg_i <= ra;
		cmd_wdata_i <= wd;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (cmd_ready_o !== 1'b1 && n < 20000);
		cmd_valid_i <= 1'b0;
		while (rsp_valid_o !== 1'b1 && n < 20000)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 20000)
		begin
			err_total++;
			end_sim();
		end
	endtask
	initial
	begin
		void'($urandom(32'ha4fd3f85));
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			r = (i == 0) ? 8'h14 : (i == 1) ? 8'h15 : 8'($urandom_range(255, 0));
			d = (i == 0) ? 16'h41a0 : 16'($urandom);
			xfer(1'b0, r, d);
			mdl[r] = int'(d);
			n_wr++;
			chk("write nack", 16'h0000, 16'(rsp_nack_o));
			xfer(1'b1, r, 16'h0000);
			chk("read nack", 16'h0000, 16'(rsp_nack_o));
			chk("read data", 16'(mdl[r]), rsp_rdata_o);
		end
		link_ready_i <= 1'b0;
		xfer(1'b0, 8'h15, 16'h1234);
		chk("refused nack", 16'h0001, 16'(rsp_nack_o));
		link_ready_i <= 1'b1;
		chk("volt kept", 16'(mdl[8'h15]), volt_set);
		timeout_en_i <= 1'b1;
		repeat (TO_CYC - 10) @(posedge clk_i);
		chk("stop early", 16'h0000, 16'(charge_stop_o));
		repeat (20) @(posedge clk_i);
		chk("stop due", 16'h0001, 16'(charge_stop_o));
		xfer(1'b0, 8'h14, 16'h0102);
		mdl[8'h14] = 32'h0000_0102;
		n_wr++;
		chk("stop clear", 16'h0000, 16'(charge_stop_o));
		timeout_en_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk("current", 16'(mdl[8'h14]), cur_set);
		chk("voltage", 16'(mdl[8'h15]), volt_set);
		chk("writes", 16'(n_wr), 16'(seen_wr));
		end_sim();
	end
endmodule
`default_nettype wire
